// ===== src/sx_pkg.sv
// constants for the skip/subtract/swap/xor execution block
// assumes an 8-bit core with 16-bit program words and AXI4-Lite for software access
package sx_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ROM_W = 16;
    localparam int unsigned ROM_AW = 10;
    localparam int unsigned RAM_AW = 5;
    // register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_OPND = 8'h04;
    localparam logic [7:0] OFF_WORK = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_TBLPTR = 8'h10;
    localparam logic [7:0] OFF_THIGH = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // command register fields
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_BIT_LSB = 8;
    localparam int unsigned CMD_ADDR_LSB = 16;
    localparam int unsigned CMD_IMM_LSB = 24;
    // flag register bit positions
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_HC = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_WRAP = 3;
    // status register bit positions
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_SKIP = 1;
    localparam int unsigned ST_CYC_LSB = 4;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    localparam int unsigned CYC_PLAIN = 1;
    localparam int unsigned CYC_SKIP = 2;
    typedef enum logic [4:0] {
        SX_NOP, SX_INC_SKIP, SX_INC_WORK_SKIP, SX_BIT_SET_SKIP, SX_BIT_CLR_SKIP,
        SX_BYTE_NIL_SKIP, SX_COPY_NIL_SKIP, SX_SUB_WORK, SX_SUB_MEM, SX_SUB_IMM,
        SX_SWAP_MEM, SX_SWAP_WORK, SX_TBL_CUR, SX_TBL_LAST, SX_XOR_WORK,
        SX_XOR_MEM, SX_XOR_IMM
    } sx_op_t;
    typedef enum logic [2:0] {
        SX_IDLE, SX_READ, SX_EXEC, SX_ROM, SX_DUMMY
    } sx_phase_t;
endpackage

// ===== src/sx_exec.sv
// execution unit for skips, subtraction, nibble exchange, table read and xor
// assumes single-cycle synchronous data memory and program memory read ports
// Notes on behaviour
// - true skip discards the prefetched instruction: two cycles, else one
// - inc_skip_zero writes memory plus one back, skips on zero sum
// - inc_to_work_skip_zero puts sum in work_register, skips on zero
// - bit_set_skip skips when the selected memory bit is one
// - bit-clear mem_nil_skip skips when the selected memory bit is zero
// - byte mem_nil_skip skips when the whole memory byte is zero
// - copy_nil_skip copies byte to work_register, skips when zero
// - minus_mem_to_work: work plus complement of memory plus one, four flags
// - minus_to_mem: same subtraction, result written to memory
// - immediate subtraction from work_register updates all four flags
// - nibble_exchange_mem swaps nibbles of memory byte in place
// - nibble_exchange_to_work puts swapped byte in work_register only
// - table_read_current_page: low byte to memory, high to table_high_latch
// - table_read_final_page: same from last page, no flag changes
// - xor memory into work_register, zero flag only
// - xor result written to memory, zero flag only
// - xor immediate into work_register, zero flag only
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module sx_exec #(
    parameter int unsigned PAGE_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // data memory port
    output logic [sx_pkg::RAM_AW-1:0] ram_addr,
    output logic ram_we,
    output logic [sx_pkg::DATA_W-1:0] ram_wdata,
    input wire logic [sx_pkg::DATA_W-1:0] ram_rdata,
    // program memory port
    output logic [sx_pkg::ROM_AW-1:0] rom_addr,
    input wire logic [sx_pkg::ROM_W-1:0] rom_rdata,
    // pipeline
    input wire logic [sx_pkg::ROM_AW-1:0] pc_page,
    output logic discard_fetch
);
    import sx_pkg::*;

    // the page offset comes from the 8-bit table pointer and at least one page bit must remain
    if (PAGE_W == 0 || PAGE_W > DATA_W || PAGE_W >= ROM_AW) begin : g_bad_page
        $error("sx_exec: PAGE_W out of range");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        sx_phase_t phase;
        sx_op_t op;
        logic [2:0] bsel;
        logic [RAM_AW-1:0] addr;
        logic [DATA_W-1:0] imm;
        logic [DATA_W-1:0] work;
        logic [3:0] flags;
        logic [DATA_W-1:0] tbl_ptr;
        logic [DATA_W-1:0] tbl_high;
        logic last_skip;
        logic [1:0] last_cycles;
        logic [RAM_AW-1:0] ram_addr;
        logic ram_we;
        logic [DATA_W-1:0] ram_wdata;
        logic [ROM_AW-1:0] rom_addr;
        logic discard;
    } sx_state_t;

    sx_state_t st, next_st;

    function automatic logic [DATA_W-1:0] nib_swap(input logic [DATA_W-1:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    // returns {wrap, hc, c, result}
    function automatic logic [DATA_W+2:0] sub8(input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b);
        logic [4:0] lo;
        logic [DATA_W:0] full;
        logic [DATA_W-1:0] nb;
        logic wrap;
        nb = ~b;
        lo = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
        full = {1'b0, a} + {1'b0, nb} + 9'h001;
        wrap = (a[7] != b[7]) && (full[7] != a[7]);
        return {wrap, lo[4], full[8], full[7:0]};
    endfunction

    always_comb begin
        logic [DATA_W-1:0] m;
        logic [DATA_W-1:0] sum;
        logic [DATA_W+2:0] sr;
        logic skip;
        logic [7:0] rd_off;
        logic [31:0] wv;
        m = ram_rdata;
        sum = 8'(m + 8'h01);
        sr = '0;
        skip = 1'b0;
        rd_off = 8'h00;
        wv = 32'h0000_0000;
        next_st = st;
        next_st.ram_we = 1'b0;
        next_st.discard = 1'b0;

        // write channel: address and data may arrive in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
            next_st.wready = 1'b0;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = AXI_OKAY;
            wv = st.w_data;
            unique case ({st.aw_addr[7:2], 2'b00})
                OFF_CMD: begin
                    // a command is only accepted while idle and with all lanes present
                    if (st.phase == SX_IDLE && st.w_strb == 4'hf) begin
                        next_st.op = sx_op_t'(wv[CMD_OP_LSB +: 5]);
                        next_st.bsel = wv[CMD_BIT_LSB +: 3];
                        next_st.addr = wv[CMD_ADDR_LSB +: RAM_AW];
                        next_st.imm = wv[CMD_IMM_LSB +: DATA_W];
                        next_st.phase = SX_READ;
                        next_st.ram_addr = wv[CMD_ADDR_LSB +: RAM_AW];
                    end else begin
                        next_st.bresp = AXI_SLVERR;
                    end
                end
                OFF_WORK: if (st.w_strb[0]) next_st.work = wv[7:0];
                OFF_FLAGS: if (st.w_strb[0]) next_st.flags = wv[3:0];
                OFF_TBLPTR: if (st.w_strb[0]) next_st.tbl_ptr = wv[7:0];
                OFF_OPND, OFF_THIGH, OFF_STAT: ;
                default: next_st.bresp = AXI_SLVERR;
            endcase
        end

        // read channel
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = AXI_OKAY;
            rd_off = {s_axi_araddr[7:2], 2'b00};
            unique case (rd_off)
                OFF_CMD: next_st.rdata = {27'h0, st.op};
                OFF_OPND: next_st.rdata = {24'h0, st.imm};
                OFF_WORK: next_st.rdata = {24'h0, st.work};
                OFF_FLAGS: next_st.rdata = {28'h0, st.flags};
                OFF_TBLPTR: next_st.rdata = {24'h0, st.tbl_ptr};
                OFF_THIGH: next_st.rdata = {24'h0, st.tbl_high};
                OFF_STAT: next_st.rdata = {26'h0, st.last_cycles, 2'b00,
                                           st.last_skip, st.phase != SX_IDLE};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = AXI_SLVERR;
                end
            endcase
        end

        unique case (st.phase)
            SX_IDLE: ;
            SX_READ: begin
                // memory read latency is one cycle
                next_st.phase = SX_EXEC;
                if (st.op == SX_TBL_CUR) begin
                    next_st.rom_addr = {pc_page[ROM_AW-1:PAGE_W], st.tbl_ptr[PAGE_W-1:0]};
                    next_st.phase = SX_ROM;
                end else if (st.op == SX_TBL_LAST) begin
                    next_st.rom_addr = {{(ROM_AW-PAGE_W){1'b1}}, st.tbl_ptr[PAGE_W-1:0]};
                    next_st.phase = SX_ROM;
                end
            end
            SX_ROM: begin
                next_st.phase = SX_EXEC;
            end
            SX_EXEC: begin
                unique case (st.op)
                    SX_INC_SKIP: begin
                        next_st.ram_we = 1'b1;
                        next_st.ram_wdata = sum;
                        skip = (sum == 8'h00);
                    end
                    SX_INC_WORK_SKIP: begin
                        next_st.work = sum;
                        skip = (sum == 8'h00);
                    end
                    SX_BIT_SET_SKIP: skip = m[st.bsel];
                    SX_BIT_CLR_SKIP: skip = !m[st.bsel];
                    SX_BYTE_NIL_SKIP: skip = (m == 8'h00);
                    SX_COPY_NIL_SKIP: begin
                        next_st.work = m;
                        skip = (m == 8'h00);
                    end
                    SX_SUB_WORK, SX_SUB_MEM, SX_SUB_IMM: begin
                        sr = sub8(st.work, (st.op == SX_SUB_IMM) ? st.imm : m);
                        next_st.flags[FLG_C] = sr[DATA_W];
                        next_st.flags[FLG_HC] = sr[DATA_W+1];
                        next_st.flags[FLG_WRAP] = sr[DATA_W+2];
                        next_st.flags[FLG_Z] = (sr[7:0] == 8'h00);
                        if (st.op == SX_SUB_MEM) begin
                            next_st.ram_we = 1'b1;
                            next_st.ram_wdata = sr[7:0];
                        end else begin
                            next_st.work = sr[7:0];
                        end
                    end
                    SX_SWAP_MEM: begin
                        next_st.ram_we = 1'b1;
                        next_st.ram_wdata = nib_swap(m);
                    end
                    SX_SWAP_WORK: next_st.work = nib_swap(m);
                    SX_TBL_CUR, SX_TBL_LAST: begin
                        next_st.ram_we = 1'b1;
                        next_st.ram_wdata = rom_rdata[7:0];
                        next_st.tbl_high = rom_rdata[15:8];
                    end
                    SX_XOR_WORK, SX_XOR_IMM: begin
                        next_st.work = st.work ^ ((st.op == SX_XOR_IMM) ? st.imm : m);
                        next_st.flags[FLG_Z] = (next_st.work == 8'h00);
                    end
                    SX_XOR_MEM: begin
                        next_st.ram_we = 1'b1;
                        next_st.ram_wdata = st.work ^ m;
                        next_st.flags[FLG_Z] = ((st.work ^ m) == 8'h00);
                    end
                    SX_NOP: ;
                    // op codes past the last one are accepted but do nothing
                    default: ;
                endcase
                next_st.last_skip = skip;
                // the prefetched word is dropped and a dummy cycle follows
                next_st.discard = skip;
                next_st.last_cycles = skip ? 2'(CYC_SKIP) : 2'(CYC_PLAIN);
                next_st.phase = skip ? SX_DUMMY : SX_IDLE;
            end
            SX_DUMMY: next_st.phase = SX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.phase <= SX_IDLE;
            st.op <= SX_NOP;
            st.work <= WORK_RST;
            st.flags <= FLAGS_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign ram_addr = st.ram_addr;
    assign ram_we = st.ram_we;
    assign ram_wdata = st.ram_wdata;
    assign rom_addr = st.rom_addr;
    assign discard_fetch = st.discard;
endmodule

// ===== verification/sx_mem_model.sv
// behavioural data memory and program memory facing sx_exec
// assumes the bench preloads data bytes through ram before each command
`timescale 1ns/1ps
module sx_mem_model (
    // clock
    input wire logic aclk,
    // data memory
    input wire logic [sx_pkg::RAM_AW-1:0] ram_addr,
    input wire logic ram_we,
    input wire logic [sx_pkg::DATA_W-1:0] ram_wdata,
    output logic [sx_pkg::DATA_W-1:0] ram_rdata,
    // program memory
    input wire logic [sx_pkg::ROM_AW-1:0] rom_addr,
    output logic [sx_pkg::ROM_W-1:0] rom_rdata
);
    import sx_pkg::*;
    logic [DATA_W-1:0] ram [2**RAM_AW];
    // read before write, so the cycle of a store still shows the old byte
    always @(posedge aclk) begin
        if (ram_we) begin
            ram[ram_addr] <= ram_wdata;
        end
        ram_rdata <= ram[ram_addr];
        // word depends on page and offset so a wrong page shows up
        rom_rdata <= {rom_addr[7:0] ^ 8'ha5, rom_addr[9:8], 6'h13};
    end
endmodule

// ===== verification/sx_exec_props.sv
// concurrent checks on the ports of sx_exec
// assumes command address and data are offered together and taken on one edge
`timescale 1ns/1ps
module sx_exec_props #(
    parameter int unsigned PAGE_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command capture
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // memories and pipeline
    input wire logic ram_we,
    input wire logic [sx_pkg::DATA_W-1:0] ram_wdata,
    input wire logic [sx_pkg::DATA_W-1:0] ram_rdata,
    input wire logic [sx_pkg::ROM_AW-1:0] rom_addr,
    input wire logic [sx_pkg::ROM_AW-1:0] pc_page,
    input wire logic discard_fetch
);
    import sx_pkg::*;
    sx_op_t op;
    logic [2:0] sel;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op <= SX_NOP;
            sel <= 3'h0;
        end else if (s_axi_awvalid && s_axi_wvalid && s_axi_wready && s_axi_awaddr == OFF_CMD) begin
            op <= sx_op_t'(s_axi_wdata[4:0]);
            sel <= s_axi_wdata[10:8];
        end
    end
    chk_we_ops: assert property (ram_we |-> op inside {SX_INC_SKIP, SX_SUB_MEM,
        SX_SWAP_MEM, SX_TBL_CUR, SX_TBL_LAST, SX_XOR_MEM}) else $error("store by wrong op");
    chk_skip_ops: assert property (discard_fetch |-> op inside {[SX_INC_SKIP:SX_COPY_NIL_SKIP]})
        else $error("discard by non-skip op");
    chk_skip_pulse: assert property (discard_fetch |=> !discard_fetch)
        else $error("discard longer than one cycle");
    chk_inc_store: assert property (ram_we && op == SX_INC_SKIP |-> ram_wdata == ram_rdata + 8'h01
        && discard_fetch == (ram_wdata == 8'h00)) else $error("increment store wrong");
    chk_swap_store: assert property (ram_we && op == SX_SWAP_MEM
        |-> ram_wdata == {ram_rdata[3:0], ram_rdata[7:4]}) else $error("swap store wrong");
    chk_bit_set: assert property (discard_fetch && op == SX_BIT_SET_SKIP |-> ram_rdata[sel])
        else $error("bit skip on clear bit");
    chk_byte_nil: assert property (discard_fetch && op == SX_BYTE_NIL_SKIP |-> $stable(ram_rdata)
        && ram_rdata == 8'h00) else $error("byte skip on nonzero");
    chk_tbl_last: assert property (ram_we && op == SX_TBL_LAST |-> &rom_addr[ROM_AW-1:PAGE_W])
        else $error("last page table read off page");
    chk_tbl_cur: assert property (ram_we && op == SX_TBL_CUR
        |-> rom_addr[ROM_AW-1:PAGE_W] == pc_page[ROM_AW-1:PAGE_W]) else $error("table page wrong");
endmodule
bind sx_exec sx_exec_props #(.PAGE_W(PAGE_W)) u_props (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .ram_we, .ram_wdata,
    .ram_rdata, .rom_addr, .pc_page, .discard_fetch);

// ===== verification/sx_exec_bench.sv
// self-checking bench: runs each op over AXI4-Lite and compares registers and memory
// assumes sx_mem_model as data and program memory
`timescale 1ns/1ps
module sx_exec_bench;
    import sx_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic ram_we, discard_fetch;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ram_wdata, ram_rdata;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [4:0] ram_addr;
    logic [9:0] rom_addr, pc_page;
    logic [15:0] rom_rdata;
    int errors = 0;
    int total_checks = 0;
    int discards = 0;
    always @(posedge aclk) begin
        if (discard_fetch === 1'b1) discards <= discards + 1;
    end
    sx_exec #(.PAGE_W(8)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .rom_addr,
        .rom_rdata, .pc_page, .discard_fetch);
    sx_mem_model u_mem (.aclk, .ram_addr, .ram_we, .ram_wdata, .ram_rdata, .rom_addr, .rom_rdata);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic final_report();
        if (errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // preload memory, run one command, then compare everything it may touch
    task automatic run_op(input logic [4:0] op, input logic [2:0] b, input logic [4:0] a,
            input logic [7:0] imm, input logic [7:0] m, input logic [7:0] w, input logic [3:0] f);
        logic [7:0] ew, em, o, x;
        logic [9:0] ra;
        logic [8:0] r;
        logic [4:0] h;
        logic [3:0] ef;
        logic [31:0] d;
        logic [1:0] rs;
        logic sk;
        int n;
        n = discards;
        ew = w;
        em = m;
        ef = f;
        sk = 1'b0;
        o = (op == 5'd9 || op == 5'd16) ? imm : m;
        ra = {(op == 5'd13) ? 2'b11 : pc_page[9:8], 8'h42};
        r = {1'b0, w} + {1'b0, ~o} + 9'h001;
        h = {1'b0, w[3:0]} + {1'b0, ~o[3:0]} + 5'h01;
        x = w ^ o;
        case (op)
            5'd1: begin em = m + 8'h01; sk = (em == 8'h00); end
            5'd2: begin ew = m + 8'h01; sk = (ew == 8'h00); end
            5'd3: sk = m[b];
            5'd4: sk = !m[b];
            5'd5: sk = (m == 8'h00);
            5'd6: begin ew = m; sk = (m == 8'h00); end
            5'd7, 5'd9: begin ew = r[7:0]; ef = {(w[7] != o[7]) && (r[7] != w[7]), r[7:0] == 8'h00, h[4], r[8]}; end
            5'd8: begin em = r[7:0]; ef = {(w[7] != o[7]) && (r[7] != w[7]), r[7:0] == 8'h00, h[4], r[8]}; end
            5'd10: em = {m[3:0], m[7:4]};
            5'd11: ew = {m[3:0], m[7:4]};
            5'd12, 5'd13: em = {ra[9:8], 6'h13};
            5'd14, 5'd16: begin ew = x; ef[FLG_Z] = (x == 8'h00); end
            5'd15: begin em = x; ef[FLG_Z] = (x == 8'h00); end
            default: ;
        endcase
        @(posedge aclk);
        u_mem.ram[a] <= m;
        wr(OFF_WORK, {24'h0, w}, rs);
        wr(OFF_FLAGS, {28'h0, f}, rs);
        wr(OFF_CMD, {imm, 3'h0, a, 5'h0, b, 3'h0, op}, rs);
        cmp(rs, AXI_OKAY);
        do rd(OFF_STAT, d, rs); while (d[ST_BUSY] === 1'b1);
        cmp(d[5:1], {sk ? 2'(CYC_SKIP) : 2'(CYC_PLAIN), 2'b00, sk});
        cmp(discards - n, {31'h0, sk});
        rd(OFF_WORK, d, rs);
        cmp(d[7:0], ew);
        rd(OFF_FLAGS, d, rs);
        cmp(d[3:0], ef);
        cmp(u_mem.ram[a], em);
        if (op == 5'd12 || op == 5'd13) begin
            rd(OFF_THIGH, d, rs);
            cmp(d[7:0], 8'h42 ^ 8'ha5);
        end
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] rs;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        pc_page = 10'h1a5;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wr(OFF_TBLPTR, 32'h42, rs);
        rd(8'h40, d, rs);
        cmp({rs, d}, {AXI_SLVERR, 32'h0});
        run_op(5'd0, 3'd0, 5'd2, 8'h00, 8'h99, 8'h77, 4'h9);
        run_op(5'd1, 3'd0, 5'd3, 8'h00, 8'hff, 8'h11, 4'h5);
        run_op(5'd1, 3'd0, 5'd4, 8'h00, 8'h41, 8'h11, 4'ha);
        run_op(5'd2, 3'd0, 5'd5, 8'h00, 8'hff, 8'h11, 4'hf);
        run_op(5'd2, 3'd0, 5'd6, 8'h00, 8'h07, 8'h11, 4'h0);
        run_op(5'd3, 3'd5, 5'd7, 8'h00, 8'h20, 8'h11, 4'hf);
        run_op(5'd3, 3'd5, 5'd8, 8'h00, 8'hdf, 8'h11, 4'h0);
        run_op(5'd4, 3'd0, 5'd9, 8'h00, 8'hfe, 8'h22, 4'h5);
        run_op(5'd4, 3'd7, 5'd10, 8'h00, 8'h80, 8'h22, 4'ha);
        run_op(5'd5, 3'd0, 5'd11, 8'h00, 8'h00, 8'h33, 4'hf);
        run_op(5'd5, 3'd0, 5'd12, 8'h00, 8'h80, 8'h33, 4'h0);
        run_op(5'd6, 3'd0, 5'd13, 8'h00, 8'h00, 8'h33, 4'h5);
        run_op(5'd6, 3'd0, 5'd31, 8'h00, 8'h3c, 8'h33, 4'ha);
        run_op(5'd7, 3'd0, 5'd14, 8'h00, 8'h01, 8'h80, 4'h0);
        run_op(5'd7, 3'd0, 5'd15, 8'h00, 8'h20, 8'h10, 4'hf);
        run_op(5'd8, 3'd0, 5'd16, 8'h00, 8'h55, 8'h55, 4'h0);
        run_op(5'd9, 3'd0, 5'd17, 8'hff, 8'h00, 8'h7f, 4'h0);
        run_op(5'd10, 3'd0, 5'd18, 8'h00, 8'ha5, 8'h11, 4'hf);
        run_op(5'd11, 3'd0, 5'd19, 8'h00, 8'h3c, 8'h11, 4'h5);
        run_op(5'd12, 3'd0, 5'd20, 8'h00, 8'h00, 8'h11, 4'ha);
        run_op(5'd13, 3'd0, 5'd21, 8'h00, 8'h00, 8'h11, 4'h5);
        run_op(5'd14, 3'd0, 5'd22, 8'h00, 8'h6b, 8'h6b, 4'hb);
        run_op(5'd15, 3'd0, 5'd0, 8'h00, 8'hf0, 8'h0f, 4'hf);
        run_op(5'd16, 3'd0, 5'd1, 8'ha5, 8'h00, 8'h5a, 4'h4);
        // a command without all byte lanes is refused and must not start
        s_axi_wstrb <= 4'h1;
        wr(OFF_CMD, 32'h0000_0001, rs);
        cmp(rs, AXI_SLVERR);
        s_axi_wstrb <= 4'hf;
        rd(OFF_STAT, d, rs);
        cmp(d[ST_BUSY], 1'b0);
        rd(OFF_OPND, d, rs);
        cmp(d, 32'h0000_00a5);
        rd(OFF_CMD, d, rs);
        cmp(d, 32'h0000_0010);
        final_report();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        final_report();
    end
endmodule
